//--- design/lpmcg_top.v
/*
 * operating-mode controller: maps the software level to clock and
 * oscillator enables, wakes on interrupt and restores the level on
 * return, and drives the divided auxiliary clock pin.
 * assumes all inputs except irq_pending come from logic on clk;
 * irq_pending may come from any domain and is synchronised here.
 * assumes software lowers irq_pending before it pulses irq_return;
 * a request still pending after the return wakes the device again.
 * assumes the clock gates sit outside and are fed by these enables.
 */
// Contract
// [R1] interrupt wakes any sleep, return restores it
// [R2] run state keeps every clock running
// [R3] sleep 0: cpu off, loop running
// [R4] sleep 1: cpu and loop off
// [R5] sleep 2: main, loop, oscillator off
// [R6] sleep 3: dc generator off too
// [R7] sleep 4: everything off, crystal stopped
// [R8] auxiliary pin divided by 1,2,4,8
// [R9] level applied within one cycle, reset runs
`timescale 1ns/1ps
`include "lpmcg_consts.vh"

module lpmcg_top (
    clk,
    sys_rst,
    level_sel,
    level_wr,
    irq_pending,
    irq_return,
    aux_tick,
    aux_div_sel,
    aux_pin_en,
    cpu_clk_en,
    aux_clk_en,
    sub_main_clk_en,
    main_clk_en,
    fll_en,
    osc_clk_en,
    dc_gen_en,
    xtal_en,
    in_isr,
    level_now,
    aux_pin_out,
    aux_pin_oe
);
    input  wire       clk;             // system clock, 250 MHz
    input  wire       sys_rst;         // synchronous reset, high
    input  wire [2:0] level_sel;       // software level code
    input  wire       level_wr;        // strobe: take level_sel
    input  wire       irq_pending;     // any interrupt request, level
    input  wire       irq_return;      // pulse: return from interrupt
    input  wire       aux_tick;        // auxiliary clock period pulse
    input  wire [1:0] aux_div_sel;     // pin ratio code
    input  wire       aux_pin_en;      // route auxiliary clock to pin
    output reg        cpu_clk_en;      // cpu clock enable
    output reg        aux_clk_en;      // auxiliary clock enable
    output reg        sub_main_clk_en; // sub_main_clock enable
    output reg        main_clk_en;     // main clock enable
    output reg        fll_en;          // frequency_locked_loop control
    output reg        osc_clk_en;      // oscillator_clock enable
    output reg        dc_gen_en;       // dc generator enable
    output reg        xtal_en;         // crystal oscillator enable
    output reg        in_isr;          // woken, servicing interrupt
    output reg  [2:0] level_now;       // stored software level
    output wire       aux_pin_out;     // divided auxiliary pin level
    output wire       aux_pin_oe;      // pin drive enable

    // one-hot controller states
    // two states only: following the stored level, or woken for service
    localparam [1:0] ST_RUN   = 2'h1;  // following stored level
    localparam [1:0] ST_WAKE  = 2'h2;  // servicing an interrupt

    // enable vector loaded by reset: every clock running
    localparam [7:0] ENV_RST  = `LPMCG_ENV_RESET;

    reg  [1:0]  state_reg;             // controller state
    reg  [1:0]  state_next;            // next controller state
    reg  [2:0]  level_reg;             // level software selected
    reg  [2:0]  level_next;            // next stored level
    reg  [2:0]  saved_reg;             // level held during service
    reg  [2:0]  saved_next;            // next saved level
    reg         irq_meta_reg;          // synchroniser first stage
    reg         irq_sync_reg;          // synchroniser second stage
    reg  [2:0]  eff_level;             // level whose enables apply
    reg  [7:0]  env;                   // enable vector for eff_level
    wire        asleep;                // stored level is not the run level

    // codes 6 and 7 count as asleep for wake, though their enables run
    assign asleep = (level_reg != `LPMCG_LVL_RUN);

    // interrupt request synchroniser
    // irq_pending is the only input from another domain; the first flop
    // may go metastable, so only the second one is read by the logic
    always @(posedge clk) begin
        if (sys_rst) begin
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
        end else begin
            irq_meta_reg <= irq_pending;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    // wake and restore sequencing
    always @* begin
        state_next = state_reg;
        level_next = level_reg;
        saved_next = saved_reg;
        case (state_reg)
            ST_RUN: begin
                // a wake outranks a write in the same cycle: the write is
                // dropped and the routine may rewrite the level to restore
                // [R1] wake from sleep
                if (irq_sync_reg && asleep) begin
                    saved_next = level_reg;
                    level_next = `LPMCG_LVL_RUN;
                    state_next = ST_WAKE;
                end else if (level_wr) begin
                    // [R9] take software level
                    level_next = level_sel;
                end
            end
            ST_WAKE: begin
                // a return outranks a rewrite in the same cycle
                if (irq_return) begin
                    // [R1] restore prior level
                    level_next = saved_reg;
                    state_next = ST_RUN;
                end else if (level_wr) begin
                    // routine rewrites level to be restored
                    saved_next = level_sel;
                end
            end
            default: begin
                // unreachable code: fall back to run with every clock on
                state_next = ST_RUN;
                level_next = `LPMCG_LVL_RESET;
            end
        endcase
    end

    // state registers
    always @(posedge clk) begin
        if (sys_rst) begin
            // [R9] run after reset
            // the saved level starts at run, so a stray return is harmless
            state_reg <= ST_RUN;
            level_reg <= `LPMCG_LVL_RESET;
            saved_reg <= `LPMCG_LVL_RESET;
        end else begin
            state_reg <= state_next;
            level_reg <= level_next;
            saved_reg <= saved_next;
        end
    end

    // enable table from the level about to be stored
    // decoding the next level, not the stored one, lets the registered
    // enables change at the same edge as level_now, one cycle after the
    // write, and no enable glitches since each comes from a flip-flop
    always @* begin
        eff_level = level_next;
        case (eff_level)
            // [R2] all clocks on
            `LPMCG_LVL_RUN:    env = `LPMCG_ENV_RUN;
            // [R3] cpu halted, loop kept
            `LPMCG_LVL_SLEEP0: env = `LPMCG_ENV_SLEEP0;
            // [R4] loop disabled
            `LPMCG_LVL_SLEEP1: env = `LPMCG_ENV_SLEEP1;
            // [R5] main and oscillator off
            `LPMCG_LVL_SLEEP2: env = `LPMCG_ENV_SLEEP2;
            // [R6] dc generator off
            `LPMCG_LVL_SLEEP3: env = `LPMCG_ENV_SLEEP3;
            // [R7] all off, crystal stopped
            `LPMCG_LVL_SLEEP4: env = `LPMCG_ENV_SLEEP4;
            // unused codes behave as run
            default:           env = `LPMCG_ENV_RUN;
        endcase
    end

    // [R9] registered enables, one cycle after the write
    always @(posedge clk) begin
        if (sys_rst) begin
            // every clock runs out of reset
            cpu_clk_en      <= ENV_RST[`LPMCG_EN_CPU];
            aux_clk_en      <= ENV_RST[`LPMCG_EN_AUX];
            sub_main_clk_en <= ENV_RST[`LPMCG_EN_SUBMAIN];
            main_clk_en     <= ENV_RST[`LPMCG_EN_MAIN];
            fll_en          <= ENV_RST[`LPMCG_EN_FLL];
            osc_clk_en      <= ENV_RST[`LPMCG_EN_OSCCLK];
            dc_gen_en       <= ENV_RST[`LPMCG_EN_DCGEN];
            xtal_en         <= ENV_RST[`LPMCG_EN_XTAL];
            in_isr          <= 1'b0;
            level_now       <= `LPMCG_LVL_RESET;
        end else begin
            cpu_clk_en      <= env[`LPMCG_EN_CPU];
            aux_clk_en      <= env[`LPMCG_EN_AUX];
            sub_main_clk_en <= env[`LPMCG_EN_SUBMAIN];
            main_clk_en     <= env[`LPMCG_EN_MAIN];
            fll_en          <= env[`LPMCG_EN_FLL];
            osc_clk_en      <= env[`LPMCG_EN_OSCCLK];
            dc_gen_en       <= env[`LPMCG_EN_DCGEN];
            xtal_en         <= env[`LPMCG_EN_XTAL];
            // in_isr rises with the all-on enables of the woken state
            in_isr          <= (state_next == ST_WAKE);
            // level_now mirrors the stored level for software to read back
            level_now       <= level_next;
        end
    end

    // gating the tick freezes the pin at its last level while the
    // auxiliary clock is stopped, instead of cutting a half period
    // [R8] auxiliary pin divider, silent while auxiliary clock is off
    lpmcg_aux_div u_aux_div (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .aux_tick (aux_tick & aux_clk_en),
        .div_sel  (aux_div_sel),
        .pin_en   (aux_pin_en),
        .pin_out  (aux_pin_out),
        .pin_oe   (aux_pin_oe)
    );
endmodule // lpmcg_top

//--- design/lpmcg_consts.vh
/*
 * constants for the operating-mode clock controller: mode codes, enable
 * vector bit positions, reset values and divider selections.
 * assumes inclusion by bare name from the design files.
 */
`ifndef LPMCG_CONSTS_VH
`define LPMCG_CONSTS_VH

// software level codes
`define LPMCG_LVL_RUN        3'h0
`define LPMCG_LVL_SLEEP0     3'h1
`define LPMCG_LVL_SLEEP1     3'h2
`define LPMCG_LVL_SLEEP2     3'h3
`define LPMCG_LVL_SLEEP3     3'h4
`define LPMCG_LVL_SLEEP4     3'h5
`define LPMCG_LVL_RESET      3'h0

// enable vector bit positions
`define LPMCG_EN_CPU         0
`define LPMCG_EN_AUX         1
`define LPMCG_EN_SUBMAIN     2
`define LPMCG_EN_MAIN        3
`define LPMCG_EN_FLL         4
`define LPMCG_EN_OSCCLK      5
`define LPMCG_EN_DCGEN       6
`define LPMCG_EN_XTAL        7
`define LPMCG_EN_W           8

// enable vectors per level
`define LPMCG_ENV_RUN        8'hff
`define LPMCG_ENV_SLEEP0     8'hfe
`define LPMCG_ENV_SLEEP1     8'hee
`define LPMCG_ENV_SLEEP2     8'hc2
`define LPMCG_ENV_SLEEP3     8'h82
`define LPMCG_ENV_SLEEP4     8'h00
`define LPMCG_ENV_RESET      8'hff

// auxiliary pin divider selections
`define LPMCG_DIV_1          2'h0
`define LPMCG_DIV_2          2'h1
`define LPMCG_DIV_4          2'h2
`define LPMCG_DIV_8          2'h3
`define LPMCG_DIVCNT_RESET   3'h0

// divider terminal counts: half the ratio minus one
`define LPMCG_DIVCNT_LAST_2  3'h0
`define LPMCG_DIVCNT_LAST_4  3'h1
`define LPMCG_DIVCNT_LAST_8  3'h3

`endif

//--- design/lpmcg_aux_div.v
/*
 * divider for the auxiliary clock shown on its shared pin.
 * assumes aux_tick is a one-cycle pulse per auxiliary clock period,
 * synchronous to clk; the pin completes one period each selected number of ticks.
 */
`timescale 1ns/1ps
`include "lpmcg_consts.vh"

module lpmcg_aux_div (
    clk,
    sys_rst,
    aux_tick,
    div_sel,
    pin_en,
    pin_out,
    pin_oe
);
    input  wire       clk;      // system clock
    input  wire       sys_rst;  // synchronous reset, high
    input  wire       aux_tick; // auxiliary clock period pulse
    input  wire [1:0] div_sel;  // ratio code 1,2,4,8
    input  wire       pin_en;   // pin routed to auxiliary clock
    output reg        pin_out;  // divided clock level
    output reg        pin_oe;   // pin drive enable

    reg  [2:0] cnt_reg;         // tick counter
    reg  [2:0] cnt_next;        // next counter value
    reg        tgl;             // toggle this tick
    wire [2:0] last_cnt;        // terminal count for ratio

    // terminal count: half the ratio minus one; ratio 1 follows the tick
    assign last_cnt = (div_sel == `LPMCG_DIV_8) ? `LPMCG_DIVCNT_LAST_8 :
                      (div_sel == `LPMCG_DIV_4) ? `LPMCG_DIVCNT_LAST_4 :
                                                  `LPMCG_DIVCNT_LAST_2;

    // counter next value and toggle decision
    always @* begin
        cnt_next = cnt_reg;
        tgl      = 1'b0;
        if (aux_tick) begin
            if (cnt_reg >= last_cnt) begin
                cnt_next = `LPMCG_DIVCNT_RESET;
                tgl      = 1'b1;
            end else begin
                cnt_next = cnt_reg + 3'h1;
            end
        end
    end

    // [R8] selectable pin division
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= `LPMCG_DIVCNT_RESET;
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_oe <= pin_en;
            if (!pin_en) begin
                // idle low, restart counting when routed again
                cnt_reg <= `LPMCG_DIVCNT_RESET;
                pin_out <= 1'b0;
            end else if (div_sel == `LPMCG_DIV_1) begin
                // ratio 1: follow the tick as a pulse train
                cnt_reg <= `LPMCG_DIVCNT_RESET;
                pin_out <= aux_tick;
            end else begin
                cnt_reg <= cnt_next;
                if (tgl) begin
                    pin_out <= ~pin_out;
                end
            end
        end
    end
endmodule // lpmcg_aux_div

//--- sim/lpmcg_exp.svh
/* expected enable vector per level code, bit 0 cpu up to bit 7 crystal.
   assumes inclusion inside a module body. */
function automatic [7:0] lpmcg_exp_env(input [2:0] code);
    case (code)
        3'h1: lpmcg_exp_env = 8'hfe; // sleep_level_0
        3'h2: lpmcg_exp_env = 8'hee; // sleep_level_1
        3'h3: lpmcg_exp_env = 8'hc2; // sleep_level_2
        3'h4: lpmcg_exp_env = 8'h82; // sleep_level_3
        3'h5: lpmcg_exp_env = 8'h00; // sleep_level_4
        default: lpmcg_exp_env = 8'hff; // full_run_state
    endcase
endfunction

//--- sim/lpmcg_chk.sv
/* checker for lpmcg_top: level map, wake and return, pin divider.
   assumes one clock and a synchronous reset; bound below. */
`timescale 1ns/1ps
module lpmcg_chk (
    input wire       clk,
    input wire       sys_rst,
    input wire [2:0] level_sel,
    input wire       level_wr,
    input wire       irq_pending,
    input wire       irq_return,
    input wire       aux_tick,
    input wire [1:0] aux_div_sel,
    input wire       aux_pin_en,
    input wire       cpu_clk_en,
    input wire       aux_clk_en,
    input wire       sub_main_clk_en,
    input wire       main_clk_en,
    input wire       fll_en,
    input wire       osc_clk_en,
    input wire       dc_gen_en,
    input wire       xtal_en,
    input wire       in_isr,
    input wire [2:0] level_now,
    input wire       aux_pin_out
);
    `include "lpmcg_exp.svh"
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [7:0] env = {xtal_en, dc_gen_en, osc_clk_en, fll_en,
                      main_clk_en, sub_main_clk_en, aux_clk_en, cpu_clk_en};
    reg  [2:0] keep_reg; // level to restore after service
    // track the stored level, rewritten during service
    always @(posedge clk) begin
        if (sys_rst) keep_reg <= 3'h0;
        else if (!in_isr) keep_reg <= level_now;
        else if (level_wr) keep_reg <= level_sel;
    end
    property p_env_map; !in_isr |-> env == lpmcg_exp_env(level_now); endproperty
    a_env_map: assert property (p_env_map) else $error("enables differ from level");
    property p_isr_run; in_isr |-> env == 8'hff && level_now == 3'h0; endproperty
    a_isr_run: assert property (p_isr_run) else $error("service not at full run");
    property p_wr_take;
        level_wr && !in_isr && !irq_pending && !$past(irq_pending) && !$past(irq_pending, 2)
        |=> level_now == $past(level_sel);
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("level write not applied");
    property p_run_irq; !in_isr && level_now == 3'h0 && !level_wr |=> !in_isr; endproperty
    a_run_irq: assert property (p_run_irq) else $error("wake from run state");
    property p_wake;
        (!in_isr && level_now != 3'h0 && !level_wr && irq_pending) [*3] |-> ##[1:2] in_isr;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on interrupt");
    property p_restore;
        in_isr && irq_return && !level_wr |=> !in_isr && level_now == $past(keep_reg);
    endproperty
    a_restore: assert property (p_restore) else $error("level not restored");
    property p_div1;
        aux_pin_en && aux_div_sel == 2'h0 && aux_clk_en ##1 aux_pin_en && aux_div_sel == 2'h0
        |-> aux_pin_out == $past(aux_tick);
    endproperty
    a_div1: assert property (p_div1) else $error("ratio one pin wrong");
    property p_pin_frozen;
        !aux_clk_en && aux_pin_en ##1 !aux_clk_en && aux_pin_en && $stable(aux_div_sel)
        ##1 aux_pin_en |-> $stable(aux_pin_out);
    endproperty
    a_pin_frozen: assert property (p_pin_frozen) else $error("pin moves while stopped");
    c_wake: cover property ($rose(in_isr));
    c_back: cover property ($fell(in_isr) && level_now == 3'h5);
    c_div8: cover property (aux_div_sel == 2'h3 && $rose(aux_pin_out));
endmodule // lpmcg_chk

bind lpmcg_top lpmcg_chk u_chk (.*);

//--- sim/testbench.sv
/* self-checking bench for lpmcg_top: levels, wake and return, pin ratios.
   assumes the checker binds itself; 250 MHz clock. */
`timescale 1ns/1ps
module testbench;
    `include "lpmcg_exp.svh"
    reg        clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg  [2:0] level_sel = 3'h0;
    reg        level_wr = 1'b0;
    reg        irq_pending = 1'b0;
    reg        irq_return = 1'b0;
    reg        aux_tick = 1'b0;
    reg  [1:0] aux_div_sel = 2'h0;
    reg        aux_pin_en = 1'b0;
    wire [7:0] env; // enables, bit 0 cpu up to bit 7 crystal
    wire       in_isr;
    wire [2:0] level_now;
    wire       pin;
    wire       pin_oe;
    integer    error_cnt = 0;
    integer    comparisons = 0;
    lpmcg_top DUT (.clk(clk), .sys_rst(sys_rst), .level_sel(level_sel), .level_wr(level_wr),
        .irq_pending(irq_pending), .irq_return(irq_return), .aux_tick(aux_tick),
        .aux_div_sel(aux_div_sel), .aux_pin_en(aux_pin_en), .cpu_clk_en(env[0]),
        .aux_clk_en(env[1]), .sub_main_clk_en(env[2]), .main_clk_en(env[3]), .fll_en(env[4]),
        .osc_clk_en(env[5]), .dc_gen_en(env[6]), .xtal_en(env[7]), .in_isr(in_isr),
        .level_now(level_now), .aux_pin_out(pin), .aux_pin_oe(pin_oe));
    initial forever #2 clk = ~clk;
    task step; @(posedge clk); #1; endtask
    task chk(input [7:0] exp, input [7:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task end_sim;
        if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task wr(input [2:0] lvl); level_sel = lvl; level_wr = 1'b1; step; level_wr = 1'b0; endtask
    // reset held two cycles, then reset values
    task t_reset;
        sys_rst = 1'b1;
        repeat (2) step;
        sys_rst = 1'b0;
        chk(8'hff, env);
        chk(8'h00, {in_isr, pin_oe, pin, 2'h0, level_now});
    endtask
    // every code written back to back
    task t_levels;
        integer c;
        for (c = 0; c < 8; c = c + 1) begin
            level_sel = c[2:0];
            level_wr = 1'b1;
            step;
            chk(lpmcg_exp_env(c[2:0]), env);
            chk({5'h0, c[2:0]}, {5'h0, level_now});
        end
        level_wr = 1'b0;
    endtask
    // interrupt in run state is ignored
    task t_run_irq;
        wr(3'h0);
        irq_pending = 1'b1;
        repeat (6) step;
        chk(8'h00, {7'h0, in_isr});
        irq_pending = 1'b0;
        repeat (3) step;
    endtask
    // wake from a level, optional rewrite, then return
    task t_wake(input [2:0] lvl, input [2:0] back);
        integer n;
        wr(lvl);
        irq_pending = 1'b1;
        n = 0;
        while (in_isr !== 1'b1 && n < 8) begin step; n = n + 1; end
        chk(8'h01, {7'h0, in_isr});
        if (n == 8) end_sim;
        chk(8'hff, env);
        irq_pending = 1'b0;
        repeat (3) step;
        if (back != lvl) wr(back);
        irq_return = 1'b1;
        step;
        irq_return = 1'b0;
        chk(lpmcg_exp_env(back), env);
        chk({1'b0, 4'h0, back}, {in_isr, 4'h0, level_now});
    endtask
    // count pin rises over 16 ticks, one tick every 4 cycles
    task t_pin(input [1:0] sel, input [2:0] lvl, input [7:0] exp);
        integer i;
        reg     last;
        reg [7:0] rises;
        aux_div_sel = sel;
        aux_pin_en = 1'b1;
        wr(lvl);
        rises = 8'h00;
        last = pin;
        for (i = 0; i < 128; i = i + 1) begin
            aux_tick = (i % 4 == 0);
            step;
            if (i >= 64 && pin === 1'b1 && last === 1'b0) rises = rises + 8'h01;
            last = pin;
        end
        aux_tick = 1'b0;
        chk(exp, rises);
        chk(8'h01, {7'h0, pin_oe});
    endtask
    // pin driven at ratio one, then unrouted: low and undriven despite ticks
    task t_pin_off;
        aux_div_sel = 2'h0;
        aux_pin_en = 1'b1;
        aux_tick = 1'b1;
        step;
        chk(8'h03, {6'h0, pin_oe, pin});
        aux_pin_en = 1'b0;
        repeat (3) step;
        aux_tick = 1'b0;
        chk(8'h00, {6'h0, pin_oe, pin});
    endtask
    initial begin
        t_reset;
        t_levels;
        t_run_irq;
        t_wake(3'h1, 3'h1);
        t_wake(3'h2, 3'h2);
        t_wake(3'h3, 3'h5);
        t_wake(3'h4, 3'h4);
        t_wake(3'h5, 3'h2);
        t_pin(2'h0, 3'h0, 8'h10);
        t_pin(2'h1, 3'h0, 8'h08);
        t_pin(2'h2, 3'h0, 8'h04);
        t_pin(2'h3, 3'h0, 8'h02);
        t_pin(2'h1, 3'h5, 8'h00);
        t_reset;
        t_pin_off;
        end_sim;
    end
endmodule // testbench
